// ==== rtl/frac_div_defs.svh ====
`ifndef FRAC_DIV_DEFS_SVH
`define FRAC_DIV_DEFS_SVH

`define ADDR_W             8
`define DATA_W             24
`define ADDR_REF_DIV       8'h02
`define ADDR_INT_DIV       8'h03
`define ADDR_FRAC_DIV      8'h04
`define ADDR_EXACT_STEP    8'h0c
`define ADDR_OUT_DIV       8'h16
`define INT_W              19
`define FRAC_W             24
`define OUT_DIV_W          6
`define INT_MIN            19'h00014
`define INT_MAX            19'h7fffc
`define OUT_DIV_MAX        6'h3e
`define RST_REF_DIV        24'h000001
`define RST_INT_DIV        19'h00014
`define RST_FRAC_DIV       24'h000000
`define RST_EXACT_STEP     24'h000000
`define RST_OUT_DIV        6'h01

`endif

// ==== rtl/frac_div_pkg.sv ====
`include "frac_div_defs.svh"

package frac_div_pkg;

	typedef struct packed {
		logic               en;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
	} reg_write_t;

	typedef struct packed {
		logic               modulator_enable;
		logic               modulator_bypass;
	} mod_ctrl_t;

	typedef enum logic [1:0] {
		MODE_INTEGER,
		MODE_FRACTIONAL,
		MODE_EXACT
	} mod_mode_t;

endpackage : frac_div_pkg

// ==== rtl/fractional_n_divider_control.sv ====
// Overview of operation
// - output divider: one, or even two..sixty-two
// - integer ratio from register, twenty to 524284
// - integer register is 19-bit unsigned
// - fraction equals 24-bit value over 2^24
// - comparison rate is reference over ratio register
// - fixed binary modulus of 2^24
// - exact mode keeps full 24-bit accumulator
// - channel change needs only fraction write
`timescale 1ns/1ps
`default_nettype none
`include "frac_div_defs.svh"

module fractional_n_divider_control (
	input  wire logic                    clk_sys_i,
	input  wire logic                    reset_n_i,
	input  wire frac_div_pkg::reg_write_t reg_write_i,
	input  wire logic [`ADDR_W-1:0]      rd_addr_i,
	input  wire frac_div_pkg::mod_ctrl_t mod_ctrl_i,
	output logic [`DATA_W-1:0]           rd_data_o,
	output logic [`DATA_W-1:0]           reference_ratio_o,
	output logic [`INT_W:0]              feedback_ratio_o,
	output logic [`OUT_DIV_W-1:0]        output_ratio_o,
	output logic [`FRAC_W-1:0]           modulator_phase_accumulator_o,
	output frac_div_pkg::mod_mode_t      mode_o
);
	import frac_div_pkg::*;

	logic [`DATA_W-1:0]    ref_div_reg;
	logic [`INT_W-1:0]     int_div_reg;
	logic [`FRAC_W-1:0]    frac_div_reg;
	logic [`FRAC_W-1:0]    exact_step_reg;
	logic [`OUT_DIV_W-1:0] out_div_reg;
	logic                  frac_load_reg;
	logic [`FRAC_W-1:0]    frac_active_reg;
	logic [`FRAC_W-1:0]    step_active_reg;
	logic [`FRAC_W-1:0]    residue_reg;
	logic [`FRAC_W-1:0]    modulator_phase_accumulator_reg;
	logic [`FRAC_W-1:0]    exact_acc_reg;
	logic [`INT_W-1:0]     int_clamped;
	logic [2*`FRAC_W-1:0]  residue_product;
	logic [`FRAC_W:0]      exact_sum;
	logic                  exact_borrow;
	logic [`FRAC_W:0]      phase_sum;
	logic [`FRAC_W-1:0]    phase_add;
	logic                  exact_active;
	logic                  frac_active;
	logic [`OUT_DIV_W-1:0] out_div_next;
	mod_mode_t             mode_next;

	// register file
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ref_div_reg    <= `RST_REF_DIV;
			int_div_reg    <= `RST_INT_DIV;
			frac_div_reg   <= `RST_FRAC_DIV;
			exact_step_reg <= `RST_EXACT_STEP;
			out_div_reg    <= `RST_OUT_DIV;
		end
		else if (reg_write_i.en)
		begin
			case (reg_write_i.addr)
				`ADDR_REF_DIV:    ref_div_reg    <= reg_write_i.data;
				`ADDR_INT_DIV:    int_div_reg    <= reg_write_i.data[`INT_W-1:0];
				`ADDR_FRAC_DIV:   frac_div_reg   <= reg_write_i.data;
				`ADDR_EXACT_STEP: exact_step_reg <= reg_write_i.data;
				`ADDR_OUT_DIV:    out_div_reg    <= reg_write_i.data[`OUT_DIV_W-1:0];
				default:          ;
			endcase
		end
	end

	// read back; unmapped addresses read zero
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rd_data_o <= '0;
		else
		begin
			case (rd_addr_i)
				`ADDR_REF_DIV:    rd_data_o <= ref_div_reg;
				`ADDR_INT_DIV:    rd_data_o <= {{(`DATA_W-`INT_W){1'b0}}, int_div_reg};
				`ADDR_FRAC_DIV:   rd_data_o <= frac_div_reg;
				`ADDR_EXACT_STEP: rd_data_o <= exact_step_reg;
				`ADDR_OUT_DIV:    rd_data_o <= {{(`DATA_W-`OUT_DIV_W){1'b0}}, out_div_reg};
				default:          rd_data_o <= '0;
			endcase
		end
	end

	// fraction and step are staged so a write takes effect on the following cycle
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			frac_load_reg <= 1'b0;
		else
			frac_load_reg <= reg_write_i.en &&
				(reg_write_i.addr == `ADDR_FRAC_DIV || reg_write_i.addr == `ADDR_EXACT_STEP);
	end

	// residue of fraction times step count: the excess of the rounded-up fraction
	assign residue_product = frac_div_reg * exact_step_reg;

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			frac_active_reg <= `RST_FRAC_DIV;
			step_active_reg <= `RST_EXACT_STEP;
			residue_reg     <= '0;
		end
		else if (frac_load_reg)
		begin
			frac_active_reg <= frac_div_reg;
			step_active_reg <= exact_step_reg;
			residue_reg     <= residue_product[`FRAC_W-1:0];
		end
	end

	assign frac_active  = mod_ctrl_i.modulator_enable && !mod_ctrl_i.modulator_bypass;
	assign exact_active = frac_active && (step_active_reg != '0);

	// exact correction: drop one lsb residue/step times per cycle on average
	assign exact_sum    = {1'b0, exact_acc_reg} + {1'b0, residue_reg};
	assign exact_borrow = exact_active && (exact_sum >= {1'b0, step_active_reg});

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			exact_acc_reg <= '0;
		else if (frac_load_reg || !exact_active)
			exact_acc_reg <= '0;
		else if (exact_borrow)
			exact_acc_reg <= exact_sum[`FRAC_W-1:0] - step_active_reg;
		else
			exact_acc_reg <= exact_sum[`FRAC_W-1:0];
	end

	// full-length 24-bit phase accumulator, modulus 2^24 by natural wrap
	assign phase_add = (exact_borrow && frac_active_reg != '0) ? frac_active_reg - 24'h000001 : frac_active_reg;
	assign phase_sum = {1'b0, modulator_phase_accumulator_reg} + {1'b0, phase_add};

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			modulator_phase_accumulator_reg <= '0;
		else if (!frac_active)
			modulator_phase_accumulator_reg <= '0;
		else
			modulator_phase_accumulator_reg <= phase_sum[`FRAC_W-1:0];
	end

	always_comb
	begin
		if (int_div_reg < `INT_MIN)
			int_clamped = `INT_MIN;
		else if (int_div_reg > `INT_MAX)
			int_clamped = `INT_MAX;
		else
			int_clamped = int_div_reg;
	end

	// feedback ratio per comparison cycle: integer plus modulator carry
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			feedback_ratio_o <= {1'b0, `RST_INT_DIV};
		else if (frac_active)
			feedback_ratio_o <= {1'b0, int_clamped} + {{`INT_W{1'b0}}, phase_sum[`FRAC_W]};
		else
			feedback_ratio_o <= {1'b0, int_clamped};
	end

	// zero or one selects fundamental; odd values fall to the even below; cap at 62
	always_comb
	begin
		if (out_div_reg <= 6'h01)
			out_div_next = 6'h01;
		else if (out_div_reg > `OUT_DIV_MAX)
			out_div_next = `OUT_DIV_MAX;
		else
			out_div_next = {out_div_reg[`OUT_DIV_W-1:1], 1'b0};
	end

	always_comb
	begin
		if (exact_active)
			mode_next = MODE_EXACT;
		else if (frac_active)
			mode_next = MODE_FRACTIONAL;
		else
			mode_next = MODE_INTEGER;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			output_ratio_o    <= `RST_OUT_DIV;
			reference_ratio_o <= `RST_REF_DIV;
			mode_o            <= MODE_INTEGER;
		end
		else
		begin
			output_ratio_o    <= out_div_next;
			reference_ratio_o <= (ref_div_reg == '0) ? `RST_REF_DIV : ref_div_reg;
			mode_o            <= mode_next;
		end
	end

	assign modulator_phase_accumulator_o = modulator_phase_accumulator_reg;

endmodule : fractional_n_divider_control
`default_nettype wire

// ==== dv/fndc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "frac_div_defs.svh"
module fndc_props (
	input wire logic                       clk_sys_i,
	input wire logic                       reset_n_i,
	input wire frac_div_pkg::reg_write_t   reg_write_i,
	input wire logic [`ADDR_W-1:0]         rd_addr_i,
	input wire frac_div_pkg::mod_ctrl_t    mod_ctrl_i,
	input wire logic [`DATA_W-1:0]         rd_data_o,
	input wire logic [`DATA_W-1:0]         reference_ratio_o,
	input wire logic [`INT_W:0]            feedback_ratio_o,
	input wire logic [`OUT_DIV_W-1:0]      output_ratio_o,
	input wire logic [`FRAC_W-1:0]         modulator_phase_accumulator_o,
	input wire frac_div_pkg::mod_mode_t    mode_o
);
	import frac_div_pkg::*;
	wire [23:0] acc = modulator_phase_accumulator_o;
	wire        fr  = mod_ctrl_i.modulator_enable && !mod_ctrl_i.modulator_bypass;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	property p_out; output_ratio_o == 6'h01 || (!output_ratio_o[0] && output_ratio_o inside {[6'h02:6'h3e]}); endproperty
	property p_fb; feedback_ratio_o inside {[20'h00014:20'h7fffd]}; endproperty
	property p_ref; reference_ratio_o != 24'h0; endproperty
	property p_clr; !fr |=> acc == 24'h0; endproperty
	property p_int; !fr |=> mode_o == MODE_INTEGER; endproperty
	property p_frac; fr |=> mode_o != MODE_INTEGER; endproperty
	property p_rd;
		reg_write_i.en && reg_write_i.addr == 8'h04
			##1 !(reg_write_i.en && reg_write_i.addr == 8'h04) && rd_addr_i == 8'h04
			##1 rd_addr_i == 8'h04
			|=> rd_data_o == $past(reg_write_i.data, 3);
	endproperty
	property p_step;
		(!reg_write_i.en && mode_o == MODE_FRACTIONAL)[*4] |-> acc - $past(acc) == $past(acc) - $past(acc, 2);
	endproperty
	a_out: assert property (p_out) else $error("output ratio not one or even");
	a_fb: assert property (p_fb) else $error("feedback ratio out of range");
	a_ref: assert property (p_ref) else $error("reference ratio zero");
	a_clr: assert property (p_clr) else $error("accumulator not cleared");
	a_int: assert property (p_int) else $error("mode not integer");
	a_frac: assert property (p_frac) else $error("mode not fractional");
	a_rd: assert property (p_rd) else $error("fraction readback wrong");
	a_step: assert property (p_step) else $error("accumulator step not constant");
	c_exact: cover property (mode_o == MODE_EXACT);
	c_frac: cover property (mode_o == MODE_FRACTIONAL);
	c_wr: cover property (reg_write_i.en && reg_write_i.addr == 8'h04);
endmodule : fndc_props
bind fractional_n_divider_control fndc_props u_props (.*);
`default_nettype wire

// ==== dv/fractional_n_divider_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "frac_div_defs.svh"
`define CHK(n, a, e) begin compares++; if ((a) !== (e)) begin n_errors++; $display("ERROR %s exp %h got %h", n, e, a); end end
module fractional_n_divider_control_tb;
	import frac_div_pkg::*;
	logic        clk_sys_i = 1'b0;
	logic        reset_n_i = 1'b0;
	reg_write_t  reg_write_i = '0;
	logic [7:0]  rd_addr_i = 8'h00;
	mod_ctrl_t   mod_ctrl_i = '{1'b0, 1'b1};
	logic [23:0] rd_data_o, reference_ratio_o, acc, a0;
	logic [19:0] feedback_ratio_o, s;
	logic [5:0]  output_ratio_o;
	mod_mode_t   mode_o;
	int          n_errors = 0;
	int          compares = 0;
	logic [7:0]  ad [5] = '{8'h02, 8'h03, 8'h04, 8'h0c, 8'h16};
	logic [23:0] rv [5] = '{24'h1, 24'h14, 24'h0, 24'h0, 24'h1};
	logic [23:0] mv [5] = '{24'hffffff, 24'h7ffff, 24'hffffff, 24'hffffff, 24'h3f};
	logic [5:0]  ov [5] = '{6'h00, 6'h02, 6'h03, 6'h3e, 6'h3f};
	logic [5:0]  oe [5] = '{6'h01, 6'h02, 6'h02, 6'h3e, 6'h3e};
	logic [23:0] iv [3] = '{24'h5, 24'h7ffff, 24'h38};
	logic [19:0] ie [3] = '{20'h14, 20'h7fffc, 20'h38};
	fractional_n_divider_control uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_write_i(reg_write_i),
		.rd_addr_i(rd_addr_i), .mod_ctrl_i(mod_ctrl_i), .rd_data_o(rd_data_o), .reference_ratio_o(reference_ratio_o),
		.feedback_ratio_o(feedback_ratio_o), .output_ratio_o(output_ratio_o),
		.modulator_phase_accumulator_o(acc), .mode_o(mode_o));
	initial forever #10 clk_sys_i = ~clk_sys_i;
	task automatic at(input int n);
		repeat (n) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : at
	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge clk_sys_i);
		reg_write_i <= '{1'b1, a, d};
		@(posedge clk_sys_i);
		reg_write_i.en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [23:0] e);
		@(posedge clk_sys_i);
		rd_addr_i <= a;
		at(2);
		`CHK("rd_data_o", rd_data_o, e)
	endtask : rd
	task automatic dl(input int n, input logic [23:0] e);
		a0 = acc;
		at(n);
		`CHK("accumulator step", acc - a0, e)
	endtask : dl
	task automatic end_of_test();
		$display("n_errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	initial
	begin
		#1000000;
		n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (16) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		for (int i = 0; i < 5; i++)
			rd(ad[i], rv[i]);
		for (int i = 0; i < 5; i++)
		begin
			wr(ad[i], 24'hffffff);
			rd(ad[i], mv[i]);
		end
		wr(8'h05, 24'h123456);
		rd(8'h05, 24'h0);
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h16, {18'h0, ov[i]});
			at(2);
			`CHK("output_ratio_o", output_ratio_o, oe[i])
		end
		wr(8'h02, 24'h0);
		at(2);
		`CHK("reference_ratio_o", reference_ratio_o, 24'h1)
		wr(8'h02, 24'h5);
		at(2);
		`CHK("reference_ratio_o", reference_ratio_o, 24'h5)
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h03, iv[i]);
			at(3);
			`CHK("feedback_ratio_o", feedback_ratio_o, ie[i])
		end
		`CHK("accumulator", acc, 24'h0)
		wr(8'h0c, 24'h0);
		wr(8'h04, 24'h800000);
		mod_ctrl_i <= '{1'b1, 1'b0};
		at(6);
		`CHK("mode_o", mode_o, MODE_FRACTIONAL)
		s = feedback_ratio_o;
		at(1);
		`CHK("feedback pair", feedback_ratio_o + s, 20'd113)
		wr(8'h04, 24'h19999a);
		at(4);
		dl(10, 24'h4);
		wr(8'h0c, 24'ha);
		at(4);
		`CHK("mode_o", mode_o, MODE_EXACT)
		dl(10, 24'h0);
		@(posedge clk_sys_i);
		rd_addr_i <= 8'h04;
		wr(8'h04, 24'h333334);
		at(4);
		dl(10, 24'h0);
		rd(8'h03, 24'h38);
		@(posedge clk_sys_i);
		mod_ctrl_i <= '{1'b0, 1'b1};
		at(3);
		`CHK("mode_o", mode_o, MODE_INTEGER)
		`CHK("feedback_ratio_o", feedback_ratio_o, 20'h38)
		end_of_test();
	end
endmodule : fractional_n_divider_control_tb
`default_nettype wire
